// ==== core/mbs_bus_strobes.v ====
/*
 * memory bus strobes for one chip select access: boot straps, column
 * strobes, byte enables, read/write, output and write enables, and cycle
 * termination by acknowledge and error. assumes the master presents a
 * request with address, size, direction and the decoded chip select
 * settings held steady until done; acknowledge is already synchronous.
 */
`include "mbs_map.vh"

// Contract
// - sample address lines as straps at power-up
// - address 24:23 selects chip select 0 boot
// - code 11 turns top pins into strobes
// - pin-select flags one, zero for code 11
// - wait 0000 or 1111, size 01 for 11
// - valid flag zero only for code 00
// - column strobes only for dram chip selects
// - column strobe low while column address valid
// - one column strobe per active byte lane
// - lane mapping by endian for 32-bit ports
// - 16-bit uses strobes 3,2; 8-bit strobe 3
// - direction high for read, low for write
// - output enable low during read cycle
// - write enable low during write cycle
// - one active-low byte enable per valid byte
// - byte 3 only, half 3-2, word all
// - byte enables share lane map, sdram mask
// - sample acknowledge on rising edge, capture data
// - error pin means error or burst end
// - ack,err: 00 burst,01 normal,10 error,11 wait
module mbs_bus_strobes #(
    parameter WAIT_W = 4
) (
    input  wire                     ref_clk,
    input  wire                     rst_n,
    input  wire [`MBS_ADDR_W-1:0]   addr_pad_in,
    input  wire                     req,
    input  wire [`MBS_ADDR_W-1:0]   req_addr,
    input  wire                     req_read,
    input  wire [1:0]               req_size,
    input  wire                     req_big_endian,
    input  wire                     cs_hit_boot,
    input  wire                     cs_dram,
    input  wire                     cs_sdram,
    input  wire                     cs_burst,
    input  wire                     cs_ext_term,
    input  wire [1:0]               cs_port_size,
    input  wire [WAIT_W-1:0]        cs_wait,
    input  wire                     req_last,
    input  wire                     req_fault,
    input  wire [31:0]              data_in,
    input  wire                     transfer_ack_n_in,
    input  wire                     transfer_error_n_in,
    output reg  [`MBS_ADDR_W-1:0]   addr_out,
    output reg                      read_write,
    output reg                      oe_n,
    output reg                      we_n,
    output reg  [3:0]               col_strobe_n,
    output reg  [3:0]               byte_enable_n,
    output reg                      boot_chip_select_n,
    output reg                      transfer_ack_n_out,
    output reg                      transfer_ack_n_oe,
    output reg                      transfer_error_n_out,
    output reg                      transfer_error_n_oe,
    output reg  [31:0]              rd_data,
    output reg                      done,
    output reg  [1:0]               term_code,
    output reg                      boot_valid_out,
    output reg  [1:0]               boot_port_size,
    output reg  [3:0]               boot_wait_out,
    output reg                      addr27_sel_out,
    output reg                      addr26_sel_out
);

    ////////////////////////////////////////////////////////////////////////
    // state machine codes, one hot
    localparam ST_IDLE = 4'h1;
    localparam ST_ROW  = 4'h2;
    localparam ST_XFER = 4'h4;
    localparam ST_END  = 4'h8;

    reg  [3:0]          state_r;
    reg  [3:0]          state_nxt;
    reg  [WAIT_W-1:0]   wait_r;
    reg  [WAIT_W-1:0]   wait_nxt;
    reg  [3:0]          lanes;
    reg  [1:0]          term_nxt;
    reg                 end_nxt;
    wire                a27_sel;
    wire                a26_sel;
    wire [3:0]          bt_wait;
    wire [1:0]          bt_ps;
    wire                bt_valid;

    ////////////////////////////////////////////////////////////////////////
    // strap capture, reading the pads while reset is held
    mbs_boot_strap u_strap (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .strap_in          (addr_pad_in[`MBS_STRAP_HI:`MBS_STRAP_LO]),
        .addr27_pin_select (a27_sel),
        .addr26_pin_select (a26_sel),
        .boot_wait         (bt_wait),
        .port_size         (bt_ps),
        .boot_valid        (bt_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // lane decode: active-high mask, bit 3 is d31:d24
    function [3:0] lane_mask;
        input [1:0] ps;
        input [1:0] sz;
        input [1:0] a;
        input       big;
        reg   [1:0] pos;
        begin
            pos = big ? ~a : a;                    // big endian flips byte order
            lane_mask = `MBS_LANES_NONE;
            case (ps)
                `MBS_PS_32: begin
                    case (sz)
                        `MBS_SZ_BYTE: lane_mask = 4'h1 << pos;
                        `MBS_SZ_HALF: lane_mask = pos[1] ? `MBS_LANES_HI16 : 4'h3;
                        default:      lane_mask = `MBS_LANES_ALL;
                    endcase
                end
                `MBS_PS_16: begin
                    if (sz == `MBS_SZ_BYTE)
                        lane_mask = (big ? ~a[0] : a[0]) ? `MBS_LANE3 : 4'h4;
                    else
                        lane_mask = `MBS_LANES_HI16;
                end
                default: lane_mask = `MBS_LANE3;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strobe lanes for the current request
    always @* begin
        lanes = lane_mask(cs_port_size, req_size, req_addr[1:0],
                          req_big_endian);
    end

    ////////////////////////////////////////////////////////////////////////
    // termination decode from the sampled ack/error pair, or from the wait count and fault/burst flags for internal selects
    always @* begin
        term_nxt = `MBS_TERM_WAIT;
        end_nxt  = 1'b0;
        if (cs_ext_term) begin
            term_nxt = {transfer_ack_n_in, transfer_error_n_in};
            end_nxt  = (term_nxt != `MBS_TERM_WAIT);
        end else if (wait_r == {WAIT_W{1'b0}}) begin
            end_nxt = 1'b1;
            if (req_fault)
                term_nxt = `MBS_TERM_ERROR;
            else if (cs_burst && req_last)
                term_nxt = `MBS_TERM_BURST;
            else
                term_nxt = `MBS_TERM_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencing: idle, dram row phase, transfer, end
    always @* begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        case (state_r)
            ST_IDLE: begin
                wait_nxt = cs_wait;
                if (req)
                    state_nxt = cs_dram ? ST_ROW : ST_XFER;
            end
            ST_ROW:  state_nxt = ST_XFER;
            ST_XFER: begin
                if (end_nxt)
                    state_nxt = ST_END;
                else if (wait_r != {WAIT_W{1'b0}})
                    wait_nxt = wait_r - {{(WAIT_W-1){1'b0}}, 1'b1};
            end
            ST_END:  state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pins and status
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r              <= ST_IDLE;
            wait_r               <= {WAIT_W{1'b0}};
            addr_out             <= {`MBS_ADDR_W{1'b0}};
            read_write           <= 1'b1;
            oe_n                 <= 1'b1;
            we_n                 <= 1'b1;
            col_strobe_n         <= `MBS_LANES_ALL;
            byte_enable_n        <= `MBS_LANES_ALL;
            boot_chip_select_n   <= 1'b1;
            transfer_ack_n_out   <= 1'b1;
            transfer_ack_n_oe    <= 1'b0;
            transfer_error_n_out <= 1'b1;
            transfer_error_n_oe  <= 1'b0;
            rd_data              <= 32'h00000000;
            done                 <= 1'b0;
            term_code            <= `MBS_TERM_WAIT;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            done    <= 1'b0;
            transfer_ack_n_out   <= 1'b1;
            transfer_error_n_out <= 1'b1;
            transfer_ack_n_oe    <= (state_nxt == ST_XFER) && !cs_ext_term;
            transfer_error_n_oe  <= (state_nxt == ST_XFER) && !cs_ext_term;
            if (state_nxt == ST_XFER || state_nxt == ST_ROW) begin
                addr_out   <= req_addr;
                // strapped for 16-bit boot, the top pins carry the boot strobes
                if (!a27_sel)
                    addr_out[`MBS_BOOT_OE_BIT] <= !(req_read && cs_hit_boot && bt_valid);
                if (!a26_sel)
                    addr_out[`MBS_BOOT_WE_BIT] <= !(!req_read && cs_hit_boot && bt_valid);
                read_write <= req_read;
                oe_n       <= !req_read;
                we_n       <= req_read;
                boot_chip_select_n <= !(cs_hit_boot && bt_valid);
                byte_enable_n <= ~lanes;
            end else begin
                read_write    <= 1'b1;
                oe_n          <= 1'b1;
                we_n          <= 1'b1;
                boot_chip_select_n <= 1'b1;
                byte_enable_n <= `MBS_LANES_ALL;
                // boot strobes idle high between cycles
                if (!a27_sel)
                    addr_out[`MBS_BOOT_OE_BIT] <= 1'b1;
                if (!a26_sel)
                    addr_out[`MBS_BOOT_WE_BIT] <= 1'b1;
            end
            // column strobes only once the row is out, dram chip selects only
            if (state_nxt == ST_XFER && cs_dram && !cs_sdram)
                col_strobe_n <= ~lanes;
            else
                col_strobe_n <= `MBS_LANES_ALL;
            // block-driven termination pulses on the final cycle when cs_ext_term is low
            if (state_r == ST_XFER && end_nxt && !cs_ext_term) begin
                transfer_ack_n_out   <= term_nxt[1];
                transfer_error_n_out <= term_nxt[0];
                transfer_ack_n_oe    <= 1'b1;
                transfer_error_n_oe  <= 1'b1;
            end
            // data captured on the edge that sees acknowledge low
            if (state_r == ST_XFER && end_nxt) begin
                done      <= 1'b1;
                term_code <= term_nxt;
                if (req_read && !term_nxt[1])
                    rd_data <= data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boot configuration, exported from flops
    always @(posedge ref_clk) begin
        boot_valid_out <= bt_valid;
        boot_port_size <= bt_ps;
        boot_wait_out  <= bt_wait;
        addr27_sel_out <= a27_sel;
        addr26_sel_out <= a26_sel;
    end

endmodule // mbs_bus_strobes

// ==== core/mbs_map.vh ====
/*
 * bit positions, strap codes, boot presets and lane codes for the memory bus
 * strobe and boot block. assumes inclusion by bare name from the core files.
 */
`ifndef MBS_MAP_VH
`define MBS_MAP_VH

// strap positions on the sampled address bus
`define MBS_STRAP_HI        24
`define MBS_STRAP_LO        23
`define MBS_ADDR_W          28
`define MBS_BOOT_OE_BIT     27
`define MBS_BOOT_WE_BIT     26

// boot strap codes on address 24:23
`define MBS_BOOT_OFF        2'h0
`define MBS_BOOT_SRAM32     2'h1
`define MBS_BOOT_DRAM32     2'h2
`define MBS_BOOT_SRAM16     2'h3

// preset field values
`define MBS_WAIT_NONE       4'h0
`define MBS_WAIT_MAX        4'hF
`define MBS_PS_32           2'h0
`define MBS_PS_16           2'h1
`define MBS_PS_8            2'h2

// transfer sizes requested by the bus master
`define MBS_SZ_BYTE         2'h0
`define MBS_SZ_HALF         2'h1
`define MBS_SZ_WORD         2'h2

// lane masks, bit 3 is d31:d24, active high inside the block
`define MBS_LANES_NONE      4'h0
`define MBS_LANES_ALL       4'hF
`define MBS_LANES_HI16      4'hC
`define MBS_LANE3           4'h8

// termination codes as {ack_n, err_n}
`define MBS_TERM_BURST      2'h0
`define MBS_TERM_NORMAL     2'h1
`define MBS_TERM_ERROR      2'h2
`define MBS_TERM_WAIT       2'h3

`endif

// ==== core/mbs_boot_strap.v ====
/*
 * captures the boot straps from the address bus while reset is held and
 * decodes them into chip select 0 presets. assumes the address pads read
 * one when floating and zero when pulled low, synchronous to ref_clk.
 */
`include "mbs_map.vh"

module mbs_boot_strap (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [1:0]   strap_in,
    output reg          addr27_pin_select,
    output reg          addr26_pin_select,
    output reg  [3:0]   boot_wait,
    output reg  [1:0]   port_size,
    output reg          boot_valid
);

    ////////////////////////////////////////////////////////////////////////
    // straps are caught only while reset is low, then frozen
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            addr27_pin_select <= (strap_in != `MBS_BOOT_SRAM16);
            addr26_pin_select <= (strap_in != `MBS_BOOT_SRAM16);
            boot_wait <= (strap_in == `MBS_BOOT_OFF) ? `MBS_WAIT_NONE
                                                     : `MBS_WAIT_MAX;
            port_size <= (strap_in == `MBS_BOOT_SRAM16) ? `MBS_PS_16
                                                        : `MBS_PS_32;
            boot_valid <= (strap_in != `MBS_BOOT_OFF);
        end
    end

endmodule // mbs_boot_strap

// ==== testbench/mbs_bus_props.sv ====
/* concurrent checks on the memory bus strobe block, seen at its ports.
   assumes one clock domain and a bind placed in the bench top file. */
module mbs_bus_props #(
    parameter WAIT_W = 4
) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              req,
    input wire logic              req_read,
    input wire logic [1:0]        req_size,
    input wire logic              cs_dram,
    input wire logic              cs_sdram,
    input wire logic              cs_burst,
    input wire logic              cs_ext_term,
    input wire logic [1:0]        cs_port_size,
    input wire logic [WAIT_W-1:0] cs_wait,
    input wire logic              req_last,
    input wire logic              req_fault,
    input wire logic              transfer_ack_n_in,
    input wire logic              transfer_error_n_in,
    input wire logic              read_write,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic [3:0]        col_strobe_n,
    input wire logic [3:0]        byte_enable_n,
    input wire logic              done,
    input wire logic [1:0]        term_code,
    input wire logic              boot_valid_out,
    input wire logic [1:0]        boot_port_size,
    input wire logic [3:0]        boot_wait_out,
    input wire logic              addr27_sel_out,
    input wire logic              addr26_sel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire act = byte_enable_n != 4'hF;
    // a plain static request taken from idle, and its bounded completion
    sequence s_take;
        $rose(req) && !cs_ext_term && !cs_dram && cs_wait == '0;
    endsequence
    sequence s_finish;
        ##[2:3] done;
    endsequence
    chk_int_latency: assert property (s_take |-> s_finish)
        else $error("internal cycle did not end in time");
    chk_rw_strobe: assert property (s_take |-> ##[0:2] (req_read ? !oe_n : !we_n))
        else $error("read or write strobe missing");
    chk_read_dir: assert property (!oe_n |-> read_write && req_read)
        else $error("output enable outside a read");
    chk_write_dir: assert property (!we_n |-> !read_write && !req_read)
        else $error("write enable outside a write");
    chk_cas_dram: assert property (col_strobe_n != 4'hF |-> cs_dram && !cs_sdram)
        else $error("column strobe on a non dram select");
    chk_cas_lanes: assert property (col_strobe_n != 4'hF
        |-> col_strobe_n == byte_enable_n)
        else $error("column strobes and byte enables differ");
    chk_word_lanes: assert property (act && req_size == 2'h2 && cs_port_size == 2'h0
        |-> byte_enable_n == 4'h0)
        else $error("word transfer without all lanes");
    chk_byte_lane: assert property (act && req_size == 2'h0 |-> $onehot(~byte_enable_n))
        else $error("byte transfer not on one lane");
    chk_narrow_lanes: assert property (act && cs_port_size != 2'h0
        |-> byte_enable_n[1:0] == 2'h3)
        else $error("narrow port uses a low lane");
    chk_ext_term: assert property (done && cs_ext_term
        |-> term_code == $past({transfer_ack_n_in, transfer_error_n_in}))
        else $error("external termination code lost");
    chk_int_term: assert property (done && !cs_ext_term |-> term_code ==
        (req_fault ? 2'h2 : (cs_burst && req_last) ? 2'h0 : 2'h1))
        else $error("internal termination code wrong");
    chk_boot_frozen: assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable({boot_valid_out,
        boot_port_size, boot_wait_out, addr27_sel_out, addr26_sel_out}))
        else $error("boot settings changed after reset");
    chk_boot_table: assert property ($past(rst_n) && $past(rst_n, 2) |-> addr27_sel_out ==
        addr26_sel_out && addr27_sel_out == (boot_port_size == 2'h0)
        && boot_wait_out == {4{boot_valid_out}})
        else $error("boot presets inconsistent");
endmodule // mbs_bus_props

// ==== testbench/mbs_mem_model.sv ====
/* behavioural external memory on one chip select: answers a strobed cycle
   with a termination code after a set delay. assumes the bench merges its
   acknowledge and error with the block's own drivers, pull-ups high. */
module mbs_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        active,
    input  wire logic [3:0]  delay,
    input  wire logic [1:0]  term,
    input  wire logic [31:0] pat,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    output logic             ack_n,
    output logic             err_n,
    output logic [31:0]      data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  wait_r = 4'h0;
    logic [31:0] last_r = 32'h0;
    wire         fire   = active && !(oe_n && we_n) && wait_r >= delay;
    // count cycles of the current strobe, remember the last data level
    always @(posedge ref_clk) begin
        if (!rst_n || (oe_n && we_n))
            wait_r <= 4'h0;
        else if (wait_r != 4'hF)
            wait_r <= wait_r + 4'h1;
        last_r <= data;
    end
    // drive termination while answering, release to the pull-up otherwise
    assign ack_n = fire ? term[1] : 1'b1;
    assign err_n = fire ? term[0] : 1'b1;
    // released data lanes keep changing so stale values never match
    assign data  = fire ? pat : ~last_r;
endmodule // mbs_mem_model

// ==== testbench/mbs_bus_strobes_tb.sv ====
/* self-checking bench for the memory bus strobe block: boot straps, lane
   strobes and termination. assumes the memory model and the bound checker
   sit beside the block on one 125 MHz clock. */
`include "mbs_map.vh"
module mbs_bus_strobes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = '0, rst_n = '0, req = '0, req_read = '0, req_big_endian = '0;
    logic        cs_hit_boot = '0, cs_dram = '0, cs_sdram = '0, cs_burst = '0;
    logic        cs_ext_term = '0, req_last = '0, req_fault = '0, m_act = '0;
    logic [27:0] addr_pad_in = '1, req_addr = '0, addr_out;
    logic [1:0]  req_size = '0, cs_port_size = '0, m_term = '0, term_code, boot_port_size;
    logic [3:0]  cs_wait = '0, m_dly = '0, col_strobe_n, byte_enable_n, boot_wait_out;
    logic [31:0] m_pat = '0, data_in, rd_data;
    logic        transfer_ack_n_in, transfer_error_n_in, m_ack_n, m_err_n, read_write, oe_n;
    logic        we_n, boot_chip_select_n, transfer_ack_n_out, transfer_ack_n_oe, done;
    logic        transfer_error_n_out, transfer_error_n_oe, boot_valid_out;
    logic        addr27_sel_out, addr26_sel_out, oe_s, we_s, rw_s;
    logic [3:0]  be_s, cas_s, exp;
    logic        cs_s;
    logic [27:0] ad_s;
    logic [1:0]  tp_s;
    logic [15:0] r;
    int          mismatches = 0, compares = 0;
    // termination rows: flags {ext,fault,burst,last}, delay or wait, model code, expected
    logic [15:0] rows [7] = '{16'h4002, 16'h3000, 16'h2001, 16'h0301, 16'h8011,
                              16'h8322, 16'h8100};

    always #4 ref_clk = ~ref_clk;
    // shared wires: whoever enables drives, else the pull-up
    assign transfer_ack_n_in   = transfer_ack_n_oe ? transfer_ack_n_out : m_ack_n;
    assign transfer_error_n_in = transfer_error_n_oe ? transfer_error_n_out : m_err_n;
    mbs_bus_strobes #(.WAIT_W(4)) dut (.*);
    mbs_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n), .active(m_act), .delay(m_dly),
        .term(m_term), .pat(m_pat), .oe_n(oe_n), .we_n(we_n), .ack_n(m_ack_n),
        .err_n(m_err_n), .data(data_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // expected active lanes, bit 3 is the top lane
    function automatic logic [3:0] lanes(logic [1:0] ps, logic [1:0] sz, logic [1:0] a,
                                         logic big);
        logic [1:0] b;
        b = big ? ~a : a;
        if (ps == 2'h2) return 4'h8;
        if (ps == 2'h1) return (sz == 2'h1) ? 4'hC : (b[0] ? 4'h8 : 4'h4);
        if (sz == 2'h2) return 4'hF;
        if (sz == 2'h1) return b[1] ? 4'hC : 4'h3;
        return 4'h1 << b;
    endfunction
    // one request held until done, strobes recorded on the way
    task automatic access();
        int n;
        be_s = 4'hF;
        cas_s = 4'hF;
        oe_s = 1'b0;
        we_s = 1'b0;
        {rw_s, cs_s, ad_s} = 'x;
        req = 1'b1;
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            @(negedge ref_clk);
            if (byte_enable_n != 4'hF) be_s = byte_enable_n;
            if (col_strobe_n != 4'hF) cas_s = col_strobe_n;
            if (!oe_n || !we_n) {rw_s, cs_s, ad_s} = {read_write, boot_chip_select_n, addr_out};
            oe_s |= !oe_n;
            we_s |= !we_n;
        end
        tp_s = {transfer_ack_n_in, transfer_error_n_in};
        if (done !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        req = 1'b0;
        @(negedge ref_clk);
    endtask
    // reset with a strap code, then let the pads carry other levels
    task automatic boot(logic [1:0] code);
        rst_n = 1'b0;
        addr_pad_in = {3'h7, code, 23'h7FFFFF};
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        addr_pad_in = ~addr_pad_in;
        repeat (3) @(negedge ref_clk);
        check("pin select", {addr27_sel_out, addr26_sel_out}, code == 2'h3 ? 0 : 3);
        check("boot wait", boot_wait_out, code == 2'h0 ? 4'h0 : 4'hF);
        check("boot size", boot_port_size, code == 2'h3 ? 2'h1 : 2'h0);
        check("boot valid", boot_valid_out, code != 2'h0);
        check("boot keep", addr27_sel_out, code != 2'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int c = 0; c < 4; c++) boot(2'(c));
        for (int ps = 0; ps < 3; ps++)
            for (int sz = 0; sz < 3 - ps; sz++)
                for (int big = 0; big < 2; big++)
                    for (int a = 0; a < 4; a += (1 << sz)) begin
                        cs_port_size = 2'(ps);
                        req_size = 2'(sz);
                        req_big_endian = big[0];
                        req_addr = 28'h0123450 | 28'(a);
                        req_read = a[1] ^ big[0];
                        cs_dram = big[0] ^ sz[0];
                        cs_sdram = !cs_dram && a[0];
                        cs_hit_boot = ps[0];
                        exp = ~lanes(2'(ps), 2'(sz), 2'(a), big[0]);
                        access();
                        check("byte enables", be_s, exp);
                        check("column strobes", cas_s, cs_dram ? exp : 4'hF);
                        check("address", ad_s, {!(req_read && cs_hit_boot),
                              !(!req_read && cs_hit_boot), req_addr[25:0]});
                        check("boot select", cs_s, !cs_hit_boot);
                        check("direction", rw_s, req_read);
                        check("oe we", {oe_s, we_s}, {req_read, !req_read});
                    end
        {req_read, req_size} = {1'b1, `MBS_SZ_WORD};
        {cs_port_size, req_big_endian} = {`MBS_PS_32, 1'b0};
        {cs_dram, cs_sdram} = 2'h0;
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            {cs_ext_term, req_fault, cs_burst, req_last} = r[15:12];
            m_act = r[15];
            m_dly = r[11:8];
            cs_wait = r[15] ? 4'h0 : r[11:8];
            m_term = r[5:4];
            m_pat = {8{r[11:8]}} ^ 32'hC3A5_0F69;
            access();
            check("termination", term_code, r[1:0]);
            if (!r[15]) check("term pins", tp_s, r[1:0]);
            if (r[15] && !r[1]) check("read data", rd_data, m_pat);
        end
        give_verdict();
    end
endmodule // mbs_bus_strobes_tb

bind mbs_bus_strobes mbs_bus_props #(.WAIT_W(WAIT_W)) u_props (.*);
